/* src/spm_pkg.sv */
// constants and field layout for the serial port mode and interrupt mask block
//
// Function
// - baud source: clk, clk/8, external clock
// - length field gives five to eight bits
// - clocked bit selects synchronous operation
// - parity field: even, odd, space, mark, none, multidrop
// - stop field gives 1, 1.5, 2 bits
// - mode 00: normal transmit and receive pins
// - mode 01: received input echoed to output
// - mode 10: transmitter fed into receiver internally
// - mode 11: input pin tied to output pin
// - clock pin driven only with internal source
// - enable write sets mask bits with ones
// - disable write clears mask bits with ones
// - mask read shows enabled sources
// - bits 0-2: receive ready, transmit ready, break
// - bits 3-4: receive, transmit transfer done
// - bits 5-7: overrun, framing, parity errors
// - bits 8-9: time-out, transmitter empty
// - interrupt when flag and mask both set
`default_nettype none

package spm_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_IRQ_SET = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_VIEW = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h14;

   // ****************************************
   // mode register fields
   // ****************************************
   localparam int MODE_W = 19;
   localparam logic [MODE_W-1:0] MODE_RESET = 19'h00000;
   localparam logic [MODE_W-1:0] MODE_MASK = 19'h4fff0;
   localparam int F_SRC_LO = 4;
   localparam int F_LEN_LO = 6;
   localparam int F_SYNC = 8;
   localparam int F_PAR_LO = 9;
   localparam int F_STOP_LO = 12;
   localparam int F_CHM_LO = 14;
   localparam int F_CKDRV = 18;

   // ****************************************
   // interrupt sources
   // ****************************************
   localparam int NSRC = 10;
   localparam logic [NSRC-1:0] IRQ_VIEW_RESET = 10'h000;
   localparam int B_RX_AVAIL = 0;
   localparam int B_TX_FREE = 1;
   localparam int B_BREAK = 2;
   localparam int B_RX_DONE = 3;
   localparam int B_TX_DONE = 4;
   localparam int B_OVERRUN = 5;
   localparam int B_FRAMING = 6;
   localparam int B_PARITY = 7;
   localparam int B_TIMEOUT = 8;
   localparam int B_TX_IDLE = 9;

   // ****************************************
   // timing
   // ****************************************
   localparam int SYS_DIV = 8;
   localparam int DIV_W = 3;

   typedef enum logic [1:0] {SPM_CH_NORMAL, SPM_CH_ECHO, SPM_CH_LOCAL, SPM_CH_REMOTE} spm_channel_test_mode_t;

endpackage

`default_nettype wire

/* src/spm_core.sv */
// mode register, interrupt mask and pin routing for one serial channel
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`default_nettype none

module spm_core
#(
   parameter int DIV8 = spm_pkg::SYS_DIV
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [spm_pkg::ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // status flags from the channel
   input wire logic [spm_pkg::NSRC-1:0] channel_flags_i,
   output logic irq_o,
   // pins
   input wire logic rxd_i,
   output logic txd_o,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   // serial core side
   input wire logic tx_core_i,
   output logic rx_core_o,
   output logic tx_active_o,
   output logic rx_active_o,
   output logic baud_tick_o,
   // decoded frame setup
   output logic [3:0] data_bits_o,
   output logic sync_mode_o,
   output logic parity_en_o,
   output logic parity_odd_o,
   output logic parity_forced_o,
   output logic parity_forced_val_o,
   output logic multidrop_o,
   output logic [2:0] stop_half_bits_o,
   output logic stop_reserved_o
);
   import spm_pkg::*;

   // ****************************************
   // decode helpers
   // ****************************************
   function automatic logic [3:0] char_bits(input logic [1:0] code);
      char_bits = 4'h5 + {2'b00, code};
   endfunction

   function automatic logic is_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      is_hit = (a == ofs);
   endfunction

   function automatic logic [31:0] byte_mask(input logic [3:0] s);
      byte_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // ****************************************
   // bus slave
   // ****************************************
   logic [MODE_W-1:0] channel_mode_config;
   logic [NSRC-1:0] irq_enable_view;
   logic req;
   logic wr_fire;
   logic [31:0] wmask;
   logic [31:0] next_dat;

   assign req = cyc_i & stb_i;
   // writes land on the edge where the master sees ack
   assign wr_fire = req & we_i & ack_o;
   assign wmask = byte_mask(sel_i);

   // ~ack term keeps a held strobe from being taken twice
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
      end
      else
      begin
         ack_o <= req & ~ack_o;
      end
   end

   always_comb
   begin
      next_dat = 32'h00000000;
      if (is_hit(adr_i, OFS_MODE))
      begin
         next_dat[MODE_W-1:0] = channel_mode_config;
      end
      else if (is_hit(adr_i, OFS_IRQ_VIEW))
      begin
         next_dat[NSRC-1:0] = irq_enable_view;
      end
      else if (is_hit(adr_i, OFS_FLAGS))
      begin
         next_dat[NSRC-1:0] = channel_flags_i;
      end
   end

   // captured once per request so the value stands through the ack cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dat_o <= 32'h00000000;
      end
      else if (req & ~we_i & ~ack_o)
      begin
         dat_o <= next_dat;
      end
   end

   // ****************************************
   // mode register
   // ****************************************
   // unwritable bits masked at write time, so they always read zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         channel_mode_config <= MODE_RESET;
      end
      else if (wr_fire && is_hit(adr_i, OFS_MODE))
      begin
         channel_mode_config <= ((channel_mode_config & ~wmask[MODE_W-1:0])
            | (dat_i[MODE_W-1:0] & wmask[MODE_W-1:0])) & MODE_MASK;
      end
   end

   logic [1:0] baud_source_sel;
   logic [1:0] char_length_sel;
   logic [2:0] parity_type_sel;
   logic [1:0] stop_count_sel;
   spm_channel_test_mode_t channel_test_mode;
   logic serial_clock_drive_en;
   logic sync_sel;

   assign baud_source_sel = channel_mode_config[F_SRC_LO +: 2];
   assign char_length_sel = channel_mode_config[F_LEN_LO +: 2];
   assign sync_sel = channel_mode_config[F_SYNC];
   assign parity_type_sel = channel_mode_config[F_PAR_LO +: 3];
   assign stop_count_sel = channel_mode_config[F_STOP_LO +: 2];
   assign channel_test_mode = spm_channel_test_mode_t'(channel_mode_config[F_CHM_LO +: 2]);
   assign serial_clock_drive_en = channel_mode_config[F_CKDRV];

   // ****************************************
   // interrupt mask, one cell per source
   // ****************************************
   // mapping of bits to sources is fixed by the B_* positions
   logic set_hit;
   logic clr_hit;
   assign set_hit = wr_fire & is_hit(adr_i, OFS_IRQ_SET);
   assign clr_hit = wr_fire & is_hit(adr_i, OFS_IRQ_CLR);

   // set and clear sit at different offsets, so they never meet in one cycle
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++)
      begin : g_mask
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               irq_enable_view[gi] <= IRQ_VIEW_RESET[gi];
            end
            else if (set_hit && dat_i[gi] && wmask[gi])
            begin
               irq_enable_view[gi] <= 1'b1;
            end
            else if (clr_hit && dat_i[gi] && wmask[gi])
            begin
               irq_enable_view[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // registered so the line cannot glitch while flags and mask settle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_o <= 1'b0;
      end
      else
      begin
         irq_o <= |(channel_flags_i & irq_enable_view);
      end
   end

   // ****************************************
   // baud generator input clock
   // ****************************************
   logic [DIV_W-1:0] div_cnt;
   logic div_tick;
   logic sck_prev;
   logic next_tick;

   // free-running divider; its phase is not aligned to the mode write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_cnt <= '0;
      end
      else if (div_tick)
      begin
         div_cnt <= '0;
      end
      else
      begin
         div_cnt <= div_cnt + 1'b1;
      end
   end
   assign div_tick = (div_cnt == DIV_W'(DIV8 - 1));

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sck_prev <= 1'b0;
      end
      else
      begin
         sck_prev <= sck_i;
      end
   end

   // external edge seen one cycle late; needs sck_i well below clk_i
   always_comb
   begin
      unique case (baud_source_sel)
         2'b00: next_tick = 1'b1;
         2'b01: next_tick = div_tick;
         default: next_tick = sck_i & ~sck_prev;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         baud_tick_o <= 1'b0;
      end
      else
      begin
         baud_tick_o <= next_tick;
      end
   end

   // ****************************************
   // serial clock pin
   // ****************************************
   // with an external source the pin is an input, so never fight it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sck_o <= 1'b0;
         sck_oe_o <= 1'b0;
      end
      else
      begin
         sck_oe_o <= serial_clock_drive_en & ~baud_source_sel[1];
         // phase restarts low when the source turns internal again
         if (baud_source_sel[1])
         begin
            sck_o <= 1'b0;
         end
         else if (next_tick)
         begin
            sck_o <= ~sck_o;
         end
      end
   end

   // ****************************************
   // frame setup
   // ****************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         data_bits_o <= 4'h5;
         sync_mode_o <= 1'b0;
         parity_en_o <= 1'b1;
         parity_odd_o <= 1'b0;
         parity_forced_o <= 1'b0;
         parity_forced_val_o <= 1'b0;
         multidrop_o <= 1'b0;
         stop_half_bits_o <= 3'h2;
         stop_reserved_o <= 1'b0;
      end
      else
      begin
         data_bits_o <= char_bits(char_length_sel);
         sync_mode_o <= sync_sel;
         parity_en_o <= ~parity_type_sel[2];
         parity_odd_o <= (parity_type_sel == 3'b001);
         parity_forced_o <= (parity_type_sel[2:1] == 2'b01);
         parity_forced_val_o <= (parity_type_sel == 3'b011);
         multidrop_o <= (parity_type_sel[2:1] == 2'b11);
         // half-bit units so 1.5 stays exact; reserved codes fall back to one bit
         unique case (stop_count_sel)
            2'b01: stop_half_bits_o <= sync_sel ? 3'h2 : 3'h3;
            2'b10: stop_half_bits_o <= 3'h4;
            default: stop_half_bits_o <= 3'h2;
         endcase
         // flag only; the stop length above stays a legal one
         stop_reserved_o <= (stop_count_sel == 2'b11)
            | (sync_sel & (stop_count_sel == 2'b01));
      end
   end

   // ****************************************
   // channel routing
   // ****************************************
   // one flop of latency on each path; harmless against any baud rate
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         txd_o <= 1'b1;
         rx_core_o <= 1'b1;
         tx_active_o <= 1'b0;
         rx_active_o <= 1'b0;
      end
      else
      begin
         unique case (channel_test_mode)
            SPM_CH_NORMAL:
            begin
               txd_o <= tx_core_i;
               rx_core_o <= rxd_i;
               tx_active_o <= 1'b1;
               rx_active_o <= 1'b1;
            end
            SPM_CH_ECHO:
            begin
               txd_o <= rxd_i;
               rx_core_o <= rxd_i;
               tx_active_o <= 1'b0;
               rx_active_o <= 1'b1;
            end
            SPM_CH_LOCAL:
            begin
               txd_o <= 1'b1;
               rx_core_o <= tx_core_i;
               tx_active_o <= 1'b1;
               rx_active_o <= 1'b1;
            end
            SPM_CH_REMOTE:
            begin
               txd_o <= rxd_i;
               rx_core_o <= 1'b1;
               tx_active_o <= 1'b0;
               rx_active_o <= 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

/* dv/spm_core_properties.sv */
// assertion checker for the serial mode and interrupt mask block
`default_nettype none
module spm_props
#(
   parameter int DIV8 = 8
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [spm_pkg::ADDR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic [spm_pkg::NSRC-1:0] channel_flags_i,
   input wire logic irq_o,
   input wire logic rxd_i,
   input wire logic txd_o,
   input wire logic tx_core_i,
   input wire logic rx_core_o,
   input wire logic tx_active_o,
   input wire logic rx_active_o,
   input wire logic sck_oe_o,
   input wire logic baud_tick_o,
   input wire logic [3:0] data_bits_o,
   input wire logic sync_mode_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import spm_pkg::*;
   // ********
   // shadow of mode and mask, updated on acked writes
   // ********
   logic [MODE_W-1:0] mode;
   logic [NSRC-1:0] mask;
   logic [NSRC-1:0] hit;
   logic [1:0] chm;
   logic drv;
   logic up;
   logic wr;
   int gap;
   int run;
   assign wr = cyc_i && stb_i && we_i && ack_o;
   assign hit = channel_flags_i & mask;
   assign chm = mode[F_CHM_LO+:2];
   assign drv = mode[F_CKDRV] && !mode[F_SRC_LO+1];
   always_ff @(posedge clk_i)
   begin
      up <= !rst_i;
      gap <= baud_tick_o ? 0 : gap + 1;
      run <= (mode[F_SRC_LO+:2] != 2'h1) ? 0 : run + ((run < 99) ? 1 : 0);
      if (rst_i)
      begin
         mode <= '0;
         mask <= '0;
      end
      else if (wr && adr_i == OFS_MODE)
         mode <= dat_i[MODE_W-1:0] & MODE_MASK;
      else if (wr && adr_i == OFS_IRQ_SET)
         mask <= mask | dat_i[NSRC-1:0];
      else if (wr && adr_i == OFS_IRQ_CLR)
         mask <= mask & ~dat_i[NSRC-1:0];
   end
   // ********
   // properties
   // ********
   // up masks the first edge after reset, where past values are stale
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i || !up);
   sequence s_ack_pulse;
      ack_o ##1 !ack_o;
   endsequence
   a_ack_single: assert property ((cyc_i && stb_i && !ack_o) |=> s_ack_pulse)
      else $error("bus request not acked exactly once");
   a_normal_route: assert property ($past(chm) == 2'h0 |->
      txd_o == $past(tx_core_i) && rx_core_o == $past(rxd_i))
      else $error("normal routing wrong");
   a_echo_route: assert property ($past(chm) == 2'h1 |->
      txd_o == $past(rxd_i) && !tx_active_o)
      else $error("echo routing wrong");
   a_local_loop: assert property ($past(chm) == 2'h2 |->
      txd_o && rx_core_o == $past(tx_core_i))
      else $error("local loop routing wrong");
   a_remote_loop: assert property ($past(chm) == 2'h3 |->
      txd_o == $past(rxd_i) && !tx_active_o && !rx_active_o)
      else $error("remote loop routing wrong");
   a_clock_drive: assert property (sck_oe_o == $past(drv))
      else $error("clock pin enable wrong");
   a_char_length: assert property (data_bits_o == 4'h5 + {2'h0, $past(mode[7:6])})
      else $error("character length wrong");
   a_sync_select: assert property (sync_mode_o == $past(mode[F_SYNC]))
      else $error("sync select wrong");
   a_div8_gap: assert property (baud_tick_o && run > 2 * DIV8 + 1 |-> gap == DIV8 - 1)
      else $error("divided tick spacing wrong");
   a_irq_mask: assert property (irq_o == |$past(hit))
      else $error("interrupt line wrong");
   a_mask_read: assert property (ack_o && !we_i && adr_i == OFS_IRQ_VIEW |->
      dat_o == {22'h0, mask})
      else $error("mask read wrong");
endmodule
bind spm_core spm_props #(.DIV8(DIV8)) u_props (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .channel_flags_i(channel_flags_i), .irq_o(irq_o), .rxd_i(rxd_i),
   .txd_o(txd_o), .tx_core_i(tx_core_i), .rx_core_o(rx_core_o), .tx_active_o(tx_active_o),
   .rx_active_o(rx_active_o), .sck_oe_o(sck_oe_o), .baud_tick_o(baud_tick_o),
   .data_bits_o(data_bits_o), .sync_mode_o(sync_mode_o));
`default_nettype wire

/* dv/spm_remote.sv */
// remote serial device: sends one framed byte, clock pin still between frames
`default_nettype none
module spm_remote
(
   input wire logic clk_i,
   input wire logic send_i,
   input wire logic slow_i,
   input wire logic [7:0] data_i,
   output logic rxd_o = 1'b1,
   output logic sck_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] frame;
   int per;
   // line idles high; clock rises mid-bit so data is settled at the edge
   always @(posedge clk_i)
   begin
      if (send_i)
      begin
         frame = {1'b1, data_i, 1'b0};
         per = slow_i ? 16 : 4;
         for (int b = 0; b < 10; b++)
         begin
            rxd_o <= frame[b];
            for (int c = 0; c < per; c++)
            begin
               sck_o <= (c >= per / 2);
               @(posedge clk_i);
            end
         end
         rxd_o <= 1'b1;
         sck_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the serial mode and interrupt mask block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import spm_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i, stb_i, we_i, ack_o, irq_o, rxd, txd_o, sck, sck_o, sck_oe_o, tx_core_i;
   logic rx_core_o, tx_active_o, rx_active_o, baud_tick_o, sync_mode_o, stop_reserved_o;
   logic parity_en_o, parity_odd_o, parity_forced_o, parity_forced_val_o, multidrop_o;
   logic send, slow;
   logic [7:0] adr_i;
   logic [31:0] dat_i, dat_o, q;
   logic [9:0] flags;
   logic [3:0] data_bits_o;
   logic [2:0] stop_half_bits_o;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #10 clk_i = ~clk_i;
   spm_core #(.DIV8(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .channel_flags_i(flags), .irq_o(irq_o), .rxd_i(rxd), .txd_o(txd_o), .sck_i(sck),
      .sck_o(sck_o), .sck_oe_o(sck_oe_o), .tx_core_i(tx_core_i), .rx_core_o(rx_core_o),
      .tx_active_o(tx_active_o), .rx_active_o(rx_active_o), .baud_tick_o(baud_tick_o),
      .data_bits_o(data_bits_o), .sync_mode_o(sync_mode_o), .parity_en_o(parity_en_o),
      .parity_odd_o(parity_odd_o), .parity_forced_o(parity_forced_o),
      .parity_forced_val_o(parity_forced_val_o), .multidrop_o(multidrop_o),
      .stop_half_bits_o(stop_half_bits_o), .stop_reserved_o(stop_reserved_o));
   spm_remote u_far (.clk_i(clk_i), .send_i(send), .slow_i(slow), .data_i(8'ha5),
      .rxd_o(rxd), .sck_o(sck));
   // ********
   // helpers
   // ********
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
         n_errors++;
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1)
         n_errors++;
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         report_and_stop();
      end
   end
   // ********
   // scenarios
   // ********
   task automatic t_regs();
      rd(OFS_MODE, 32'h0);
      rd(OFS_IRQ_SET, 32'h0);
      rd(8'h2c, 32'h0);
      wb(1'b1, OFS_IRQ_VIEW, 32'hffffffff);
      rd(OFS_IRQ_VIEW, 32'h0);
      $display("registers done");
   endtask
   task automatic t_mask();
      logic [9:0] b;
      wb(1'b1, OFS_IRQ_SET, 32'hffffffff);
      rd(OFS_IRQ_VIEW, 32'h3ff);
      wb(1'b1, OFS_IRQ_CLR, 32'h155);
      rd(OFS_IRQ_VIEW, 32'h2aa);
      wb(1'b1, OFS_IRQ_SET, 32'h0);
      wb(1'b1, OFS_IRQ_CLR, 32'h0);
      rd(OFS_IRQ_VIEW, 32'h2aa);
      for (int i = 0; i < 10; i++)
      begin
         b = 10'h1 << i;
         wb(1'b1, OFS_IRQ_CLR, 32'h3ff);
         wb(1'b1, OFS_IRQ_SET, {22'h0, b});
         rd(OFS_IRQ_VIEW, {22'h0, b});
         flags <= b;
         repeat (3) @(posedge clk_i);
         chk(irq_o, 1'b1);
         flags <= ~b;
         repeat (3) @(posedge clk_i);
         chk(irq_o, 1'b0);
      end
      flags <= 10'h0;
      $display("mask done");
   endtask
   task automatic t_frame();
      logic [2:0] p;
      logic [1:0] st, ln;
      logic sy, res;
      logic [4:0] par;
      for (int i = 0; i < 8; i++)
      begin
         p = i[2:0];
         ln = i[1:0];
         sy = i[2];
         st = sy ? {i[0], 1'b0} : 2'(i % 3);
         res = st == 2'h3 || (sy && st == 2'h1);
         wb(1'b1, OFS_MODE, {18'h0, st, p, sy, ln, 6'h0});
         repeat (2) @(posedge clk_i);
         chk({data_bits_o, sync_mode_o}, {4'h5 + {2'h0, ln}, sy});
         par = {parity_en_o, parity_odd_o, parity_forced_o, parity_forced_val_o, multidrop_o};
         chk(par, {p < 4, p == 1, p[2:1] == 2'h1, p == 3, p[2:1] == 2'h3});
         chk({res, res ? 3'h0 : stop_half_bits_o}, {stop_reserved_o, 3'h2 + {1'b0, st}});
      end
      $display("frame setup done");
   endtask
   task automatic t_route();
      logic pr, pt;
      logic [1:0] e;
      for (int m = 0; m < 4; m++)
      begin
         wb(1'b1, OFS_MODE, 32'(m) << F_CHM_LO);
         @(posedge clk_i);
         send <= 1'b1;
         @(posedge clk_i);
         send <= 1'b0;
         #1;
         pr = rxd;
         pt = tx_core_i;
         repeat (48)
         begin
            @(posedge clk_i);
            tx_core_i <= ~tx_core_i;
            #1;
            e = (m == 0) ? {pt, pr} : (m == 1) ? {pr, pr} : (m == 2) ? {1'b1, pt} : {pr, 1'b1};
            chk({txd_o, rx_core_o}, e);
            chk({tx_active_o, rx_active_o}, (m == 3) ? 2'h0 : (m == 1) ? 2'h1 : 2'h3);
            pr = rxd;
            pt = tx_core_i;
         end
      end
      $display("routing done");
   endtask
   task automatic t_baud();
      int n;
      int k;
      logic ps;
      for (int s = 0; s < 4; s++)
      begin
         wb(1'b1, OFS_MODE, 32'h40000 | (32'(s) << F_SRC_LO));
         @(posedge clk_i);
         send <= 1'b1;
         slow <= 1'b1;
         @(posedge clk_i);
         send <= 1'b0;
         n = 0;
         k = 0;
         ps = sck_o;
         repeat (200)
         begin
            @(posedge clk_i);
            if (baud_tick_o === 1'b1)
               n++;
            if (sck_o !== ps)
               k++;
            ps = sck_o;
         end
         chk(n, (s == 0) ? 200 : (s == 1) ? 25 : 10);
         chk(k, (s == 0) ? 200 : (s == 1) ? 25 : 0);
         chk(sck_oe_o, s < 2);
      end
      wb(1'b1, OFS_MODE, 32'h0);
      repeat (2) @(posedge clk_i);
      chk(sck_oe_o, 1'b0);
      $display("baud source done");
   endtask
   initial
   begin
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h0;
      dat_i = 32'h0;
      flags = 10'h0;
      tx_core_i = 1'b1;
      send = 1'b0;
      slow = 1'b0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_mask();
      t_frame();
      t_route();
      t_baud();
      report_and_stop();
   end
endmodule
`default_nettype wire
